// ### qei_pkg.sv
// Shared constants, codes and carrier types of the quadrature encoder interface.
package qei_pkg;
  localparam int NUM_CH = 2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int WIN_UNIT_MS = 16;
  localparam int VEL_GATE_MS = 1000;
  localparam int MS_PER_MIN = 60000;
  localparam logic [14:0] VAL_MAX = 15'h7FFF;
  localparam logic [7:0] OFS_LIMIT = 8'h00;
  localparam logic [7:0] OFS_WINDOW = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_CH_BASE = 8'h20;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [1:0] SUB_COUNT = 2'h0;
  localparam logic [1:0] SUB_VEL = 2'h1;
  localparam logic [1:0] SUB_DIR = 2'h2;
  localparam logic [1:0] SUB_ERR = 2'h3;
  localparam int CMD_ID_LSB = 0;
  localparam int CMD_MODE_BIT = 8;
  localparam logic [7:0] ID_FIRST = 8'h01;
  localparam logic [7:0] ID_LAST = 8'h02;
  localparam int RES_DONE_BIT = 0;
  localparam int RES_BADID_BIT = 1;
  localparam int INT_BADID_BIT = 2;
  localparam int INT_W = 3;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
  typedef enum logic {
    QEI_MODE_COUNT = 1'b0,
    QEI_MODE_VEL = 1'b1
  } qei_mode_t;
  typedef enum logic [1:0] {
    QEI_DIR_STOP = 2'b00,
    QEI_DIR_REV = 2'b01,
    QEI_DIR_FWD = 2'b10
  } qei_dir_t;
  localparam logic [1:0] ERR_OK = 2'h0;
  localparam logic [1:0] ERR_A = 2'h1;
  localparam logic [1:0] ERR_B = 2'h2;
  typedef struct packed {
    qei_mode_t mode;
    logic [15:0] limit;
    logic [15:0] window;
  } qei_cfg_t;
  localparam qei_cfg_t CFG_RST = 33'h0;
  typedef struct packed {
    logic a_rise;
    logic b_rise;
    logic up;
    logic dn;
  } qei_step_t;
  typedef struct packed {
    logic [14:0] count;
    logic [14:0] vel;
    qei_dir_t dir;
    logic [1:0] err;
  } qei_stat_t;
endpackage

// ### qei_phase_dec.sv
// Phase input synchroniser, glitch filter and quadrature step decoder for one encoder.
`timescale 1ns/1ps
module qei_phase_dec (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin_a,
  input wire logic pin_b,
  output qei_pkg::qei_step_t step_ff
);
  logic [2:0] sync_a_ff;
  logic [2:0] sync_b_ff;
  logic lvl_a_ff;
  logic lvl_b_ff;
  logic nxt_a;
  logic nxt_b;
  qei_pkg::qei_step_t nxt_step;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_ff <= 3'h0;
      sync_b_ff <= 3'h0;
    end else begin
      sync_a_ff <= {sync_a_ff[1:0], pin_a};
      sync_b_ff <= {sync_b_ff[1:0], pin_b};
    end
  end

  // A level is accepted only once two later stages agree, so a one-cycle spike is dropped.
  always_comb begin
    nxt_a = (sync_a_ff[1] == sync_a_ff[2]) ? sync_a_ff[2] : lvl_a_ff;
    nxt_b = (sync_b_ff[1] == sync_b_ff[2]) ? sync_b_ff[2] : lvl_b_ff;
    nxt_step = '0;
    // Both phases moving together is not a legal quadrature step and is ignored.
    if ((nxt_a ^ lvl_a_ff) != (nxt_b ^ lvl_b_ff)) begin
      nxt_step.up = nxt_a ^ lvl_b_ff;
      nxt_step.dn = ~(nxt_a ^ lvl_b_ff);
      nxt_step.a_rise = nxt_a & ~lvl_a_ff;
      nxt_step.b_rise = nxt_b & ~lvl_b_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_a_ff <= 1'b0;
      lvl_b_ff <= 1'b0;
      step_ff <= '0;
    end else begin
      lvl_a_ff <= nxt_a;
      lvl_b_ff <= nxt_b;
      step_ff <= nxt_step;
    end
  end
endmodule

// ### qei_top.sv
// Two-channel quadrature encoder interface with APB registers and error interrupt.
`timescale 1ns/1ps
module qei_top #(
  parameter int MS_CYC = qei_pkg::MS_CYCLES,
  parameter int GATE_MS = qei_pkg::VEL_GATE_MS,
  parameter int WIN_UNIT = qei_pkg::WIN_UNIT_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [qei_pkg::NUM_CH-1:0] enc_a,
  input wire logic [qei_pkg::NUM_CH-1:0] enc_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  output logic irq_ff
);
  localparam int NCH = qei_pkg::NUM_CH;
  localparam logic [25:0] RPM_FACTOR = 26'(qei_pkg::MS_PER_MIN / GATE_MS);

  // Channel register decode: bit 3 is hit, bit 2 channel index, bits 1:0 register select.
  function automatic logic [3:0] ch_decode(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - qei_pkg::OFS_CH_BASE;
    ch_decode = 4'h0;
    if (addr >= qei_pkg::OFS_CH_BASE && rel < 8'(NCH * 16) && rel[1:0] == 2'h0) begin
      ch_decode = {1'b1, rel[4], rel[3:2]};
    end
  endfunction

  qei_pkg::qei_cfg_t cfg_ff [NCH];
  qei_pkg::qei_stat_t stat [NCH];
  qei_pkg::qei_step_t step [NCH];
  logic [NCH-1:0] apply_ff;
  logic [NCH-1:0] err_evt;
  logic [15:0] limit_stage_ff;
  logic [15:0] window_stage_ff;
  logic [1:0] result_ff;
  logic [qei_pkg::INT_W-1:0] int_stat_ff;
  logic [qei_pkg::INT_W-1:0] int_mask_ff;
  logic [qei_pkg::INT_W-1:0] int_set;
  logic [qei_pkg::INT_W-1:0] int_clr;
  logic badid_evt;
  logic [19:0] ms_cnt_ff;
  logic ms_tick_ff;
  logic access;
  logic wr_ok;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [3:0] dec;
  logic [7:0] cmd_id;

  assign access = psel & penable & ~pready_ff;
  assign wr_ok = access & pwrite & (pstrb == 4'hF) & rd_hit;
  assign cmd_id = pwdata[qei_pkg::CMD_ID_LSB +: 8];
  assign dec = ch_decode(paddr);

  // Shared 1 ms time base; the slip window (in 16 ms units) and velocity gate count its pulses.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff <= 20'h0;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= (ms_cnt_ff == 20'(MS_CYC - 1));
      ms_cnt_ff <= (ms_cnt_ff == 20'(MS_CYC - 1)) ? 20'h0 : ms_cnt_ff + 20'h1;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0;
    if (paddr == qei_pkg::OFS_LIMIT) begin
      rd_data[15:0] = limit_stage_ff;
    end else if (paddr == qei_pkg::OFS_WINDOW) begin
      rd_data[15:0] = window_stage_ff;
    end else if (paddr == qei_pkg::OFS_CMD) begin
      rd_data = 32'h0;
    end else if (paddr == qei_pkg::OFS_RESULT) begin
      rd_data[1:0] = result_ff;
    end else if (paddr == qei_pkg::OFS_INT_STAT) begin
      rd_data[qei_pkg::INT_W-1:0] = int_stat_ff;
    end else if (paddr == qei_pkg::OFS_INT_MASK) begin
      rd_data[qei_pkg::INT_W-1:0] = int_mask_ff;
    end else if (dec[3]) begin
      if (dec[1:0] == qei_pkg::SUB_COUNT) begin
        rd_data[14:0] = stat[dec[2]].count;
      end else if (dec[1:0] == qei_pkg::SUB_VEL) begin
        rd_data[14:0] = stat[dec[2]].vel;
      end else if (dec[1:0] == qei_pkg::SUB_DIR) begin
        rd_data[1:0] = stat[dec[2]].dir;
      end else begin
        rd_data[1:0] = stat[dec[2]].err;
      end
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Every access answers after one wait state; unmapped reads or writes and partial-strobe writes error.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access & (~rd_hit | (pwrite & (pstrb != 4'hF)));
      prdata_ff <= (access & ~pwrite) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_stage_ff <= 16'h0;
      window_stage_ff <= 16'h0;
      int_mask_ff <= qei_pkg::INT_MASK_RST;
    end else if (wr_ok) begin
      if (paddr == qei_pkg::OFS_LIMIT) begin
        limit_stage_ff <= pwdata[15:0];
      end else if (paddr == qei_pkg::OFS_WINDOW) begin
        window_stage_ff <= pwdata[15:0];
      end else if (paddr == qei_pkg::OFS_INT_MASK) begin
        int_mask_ff <= pwdata[qei_pkg::INT_W-1:0];
      end
    end
  end

  // A command write applies the staged setup to one channel or rejects the identifier.
  assign badid_evt = wr_ok & (paddr == qei_pkg::OFS_CMD) &
                     ((cmd_id < qei_pkg::ID_FIRST) | (cmd_id > qei_pkg::ID_LAST));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= 2'h0;
      apply_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        cfg_ff[i] <= qei_pkg::CFG_RST;
      end
    end else begin
      apply_ff <= '0;
      if (badid_evt) begin
        result_ff <= 2'h1 << qei_pkg::RES_BADID_BIT;
      end else if (wr_ok && paddr == qei_pkg::OFS_CMD) begin
        for (int i = 0; i < NCH; i++) begin
          if (cmd_id == 8'(i + 1)) begin
            cfg_ff[i].mode <= qei_pkg::qei_mode_t'(pwdata[qei_pkg::CMD_MODE_BIT]);
            cfg_ff[i].limit <= limit_stage_ff;
            cfg_ff[i].window <= window_stage_ff;
            apply_ff[i] <= 1'b1;
          end
        end
        result_ff <= 2'h1 << qei_pkg::RES_DONE_BIT;
      end
    end
  end

  // Sticky interrupt status: a new event in the clearing cycle stays set.
  always_comb begin
    int_set = '0;
    int_set[NCH-1:0] = err_evt;
    int_set[qei_pkg::INT_BADID_BIT] = badid_evt;
    int_clr = (wr_ok && paddr == qei_pkg::OFS_INT_STAT) ? pwdata[qei_pkg::INT_W-1:0] : '0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
      irq_ff <= |(((int_stat_ff & ~int_clr) | int_set) & int_mask_ff);
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [14:0] count_ff;
    logic [14:0] vel_ff;
    qei_pkg::qei_dir_t last_dir_ff;
    logic [19:0] pulse_cnt_ff;
    logic [19:0] gate_last_ff;
    logic [15:0] gate_ms_ff;
    logic gate_end;
    logic [25:0] dvd_ff;
    logic [16:0] rem_ff;
    logic [25:0] quo_ff;
    logic [4:0] bit_ff;
    logic busy_ff;
    logic [16:0] rem_sh;
    logic [1:0] err_ff;
    logic [16:0] a_run_ff;
    logic [16:0] b_run_ff;
    logic [20:0] win_ms_ff;
    logic chk_en;
    logic win_end;
    logic vel_mode;

    qei_phase_dec qei_phase_dec_i (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_a(enc_a[c]),
      .pin_b(enc_b[c]),
      .step_ff(step[c])
    );

    assign vel_mode = (cfg_ff[c].mode == qei_pkg::QEI_MODE_VEL);

    // Position wraps within 15 bits so it always stays inside 0..32767.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        count_ff <= 15'h0;
        last_dir_ff <= qei_pkg::QEI_DIR_STOP;
      end else if (apply_ff[c]) begin
        count_ff <= 15'h0;
      end else if (step[c].up) begin
        count_ff <= count_ff + 15'h1;
        last_dir_ff <= qei_pkg::QEI_DIR_FWD;
      end else if (step[c].dn) begin
        count_ff <= count_ff - 15'h1;
        last_dir_ff <= qei_pkg::QEI_DIR_REV;
      end
    end

    // Channel A rising edges are counted over a fixed gate of GATE_MS milliseconds.
    assign gate_end = ms_tick_ff & (gate_ms_ff == 16'(GATE_MS - 1));

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pulse_cnt_ff <= 20'h0;
        gate_last_ff <= 20'h0;
        gate_ms_ff <= 16'h0;
      end else if (apply_ff[c]) begin
        pulse_cnt_ff <= 20'h0;
        gate_last_ff <= 20'h0;
        gate_ms_ff <= 16'h0;
      end else begin
        if (gate_end) begin
          gate_ms_ff <= 16'h0;
          gate_last_ff <= pulse_cnt_ff;
          pulse_cnt_ff <= {19'h0, step[c].a_rise};
        end else begin
          if (ms_tick_ff) begin
            gate_ms_ff <= gate_ms_ff + 16'h1;
          end
          if (step[c].a_rise && pulse_cnt_ff != 20'hFFFFF) begin
            pulse_cnt_ff <= pulse_cnt_ff + 20'h1;
          end
        end
      end
    end

    // Serial divider: one quotient bit per cycle, far shorter than a gate period.
    assign rem_sh = {rem_ff[15:0], dvd_ff[25]};

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        dvd_ff <= 26'h0;
        rem_ff <= 17'h0;
        quo_ff <= 26'h0;
        bit_ff <= 5'h0;
        busy_ff <= 1'b0;
        vel_ff <= 15'h0;
      end else if (apply_ff[c] || !vel_mode) begin
        busy_ff <= 1'b0;
        vel_ff <= 15'h0;
      end else if (gate_end) begin
        dvd_ff <= 26'(pulse_cnt_ff) * RPM_FACTOR;
        rem_ff <= 17'h0;
        quo_ff <= 26'h0;
        bit_ff <= 5'd25;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        dvd_ff <= {dvd_ff[24:0], 1'b0};
        if (rem_sh >= {1'b0, cfg_ff[c].limit}) begin
          rem_ff <= rem_sh - {1'b0, cfg_ff[c].limit};
          quo_ff <= {quo_ff[24:0], 1'b1};
        end else begin
          rem_ff <= rem_sh;
          quo_ff <= {quo_ff[24:0], 1'b0};
        end
        bit_ff <= bit_ff - 5'h1;
        if (bit_ff == 5'h0) begin
          busy_ff <= 1'b0;
        end
      end else if (quo_ff > 26'(qei_pkg::VAL_MAX) || cfg_ff[c].limit == 16'h0) begin
        vel_ff <= (cfg_ff[c].limit == 16'h0) ? 15'h0 : qei_pkg::VAL_MAX;
      end else begin
        vel_ff <= quo_ff[14:0];
      end
    end

    // Slip check runs only in count mode with a non-zero limit.
    assign chk_en = ~vel_mode & (cfg_ff[c].limit != 16'h0);
    assign win_end = ms_tick_ff & (cfg_ff[c].window != 16'h0) &
                     (win_ms_ff + 21'h1 >= 21'(cfg_ff[c].window) * 21'(WIN_UNIT));
    assign err_evt[c] = chk_en & (err_ff == qei_pkg::ERR_OK) &
                        ((step[c].a_rise & (a_run_ff + 17'h1 > {1'b0, cfg_ff[c].limit})) |
                         (step[c].b_rise & (b_run_ff + 17'h1 > {1'b0, cfg_ff[c].limit})));

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        a_run_ff <= 17'h0;
        b_run_ff <= 17'h0;
        win_ms_ff <= 21'h0;
        err_ff <= qei_pkg::ERR_OK;
      end else if (apply_ff[c] || !chk_en) begin
        a_run_ff <= 17'h0;
        b_run_ff <= 17'h0;
        win_ms_ff <= 21'h0;
        err_ff <= apply_ff[c] ? qei_pkg::ERR_OK : err_ff;
      end else if (err_ff == qei_pkg::ERR_OK) begin
        if (win_end) begin
          win_ms_ff <= 21'h0;
          a_run_ff <= 17'h0;
          b_run_ff <= 17'h0;
        end else begin
          if (ms_tick_ff && cfg_ff[c].window != 16'h0) begin
            win_ms_ff <= win_ms_ff + 21'h1;
          end
          if (step[c].a_rise) begin
            a_run_ff <= a_run_ff + 17'h1;
            b_run_ff <= 17'h0;
          end else if (step[c].b_rise) begin
            b_run_ff <= b_run_ff + 17'h1;
            a_run_ff <= 17'h0;
          end
          if (err_evt[c]) begin
            err_ff <= step[c].a_rise ? qei_pkg::ERR_A : qei_pkg::ERR_B;
          end
        end
      end
    end

    // Direction is reported stopped when the last gate saw no pulse or, in velocity mode, speed reads zero.
    always_comb begin
      stat[c].count = count_ff;
      stat[c].vel = vel_ff;
      stat[c].err = err_ff;
      stat[c].dir = last_dir_ff;
      if (gate_last_ff == 20'h0 || (vel_mode && vel_ff == 15'h0)) begin
        stat[c].dir = qei_pkg::QEI_DIR_STOP;
      end
    end
  end
endmodule

// ### qei_top_monitor.sv
// Checker of bus timing and result codes at the encoder interface ports.
`timescale 1ns/1ps
module qei_monitor #(
  parameter int MS_CYC = qei_pkg::MS_CYCLES,
  parameter int GATE_MS = qei_pkg::VEL_GATE_MS,
  parameter int WIN_UNIT = qei_pkg::WIN_UNIT_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [qei_pkg::NUM_CH-1:0] enc_a,
  input wire logic [qei_pkg::NUM_CH-1:0] enc_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic irq_ff
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic tk = psel && penable && !pready_ff;
  wire logic mask_off = tk && pwrite && paddr == 8'h14 && pstrb == 4'hF && pwdata[2:0] == 3'h0;
  sequence rd_at(logic [7:0] a);
    tk && !pwrite && paddr == a;
  endsequence
  one_wait_a: assert property (tk |=> pready_ff)
    else $error("Access not answered after one wait state.");
  ready_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("Ready held longer than one cycle.");
  ready_cause_a: assert property (pready_ff |-> $past(psel && penable))
    else $error("Ready without an access.");
  err_with_ready_a: assert property (pslverr_ff |-> pready_ff)
    else $error("Error flag without ready.");
  rdata_idle_a: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("Read data outside the answer cycle.");
  hole_err_a: assert property (tk && paddr == 8'h18 |=> pslverr_ff)
    else $error("Unmapped access not refused.");
  strobe_err_a: assert property (tk && pwrite && pstrb != 4'hF |=> pslverr_ff)
    else $error("Partial write not refused.");
  count_range_a: assert property (rd_at(8'h20) |=> prdata_ff[31:15] == 17'h0)
    else $error("Count out of range.");
  dir_code_a: assert property (rd_at(8'h28) |=> prdata_ff <= 32'h2)
    else $error("Undefined direction code.");
  err_code_a: assert property (rd_at(8'h2C) |=> prdata_ff <= 32'h2)
    else $error("Undefined error code.");
  result_code_a: assert property (rd_at(8'h0C) |=> prdata_ff[1:0] != 2'h3)
    else $error("Result both applied and refused.");
  irq_mask_a: assert property (mask_off |-> ##[1:3] !irq_ff)
    else $error("Interrupt stays up with all events masked.");
  cover property (tk ##1 pslverr_ff);
  cover property (!irq_ff ##1 irq_ff);
  cover property (rd_at(8'h2C) ##1 prdata_ff != 32'h0);
endmodule
bind qei_top qei_monitor #(.MS_CYC(MS_CYC), .GATE_MS(GATE_MS), .WIN_UNIT(WIN_UNIT)) qei_monitor_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .enc_a(enc_a), .enc_b(enc_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff)
);

// ### qei_enc_model.sv
// Behavioural incremental encoder driving the two phase lines of one channel.
`timescale 1ns/1ps
module qei_enc_model (
  input wire logic ref_clk,
  output logic a,
  output logic b
);
  initial begin
    a = 1'h0;
    b = 1'h0;
  end
  // Forward lets phase A lead phase B; the lines settle before the task returns.
  task automatic move(input logic fwd, input int n, input int t);
    repeat (n) begin
      repeat (t) @(posedge ref_clk);
      if ((a == b) == fwd) a <= !a;
      else b <= !b;
    end
    repeat (8) @(posedge ref_clk);
  endtask
  // A slipping disc pulses one phase while the other stands still.
  task automatic slip(input logic on_a, input int n, input int h);
    repeat (2 * n) begin
      repeat (h) @(posedge ref_clk);
      if (on_a) a <= !a;
      else b <= !b;
    end
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// ### test_qei_top.sv
// Self-checking bench for the two-channel quadrature encoder interface.
`timescale 1ns/1ps
module test_qei_top;
  typedef struct packed {
    logic [31:0] d;
    logic e;
  } qei_note_t;
  localparam int GATE = 10;
  localparam int PPG = 10;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  wire logic [1:0] enc_a;
  wire logic [1:0] enc_b;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  int errors = 0;
  int compares = 0;
  int r;
  int n1;
  qei_note_t notes[$];
  qei_note_t nt;
  logic [7:0] bad[3] = '{8'h0, 8'h3, 8'hFF};

  initial forever #25 ref_clk = !ref_clk;

  qei_top #(.MS_CYC(20), .GATE_MS(GATE), .WIN_UNIT(16)) qei_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .enc_a(enc_a), .enc_b(enc_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff)
  );
  qei_enc_model enc1 (.ref_clk(ref_clk), .a(enc_a[0]), .b(enc_b[0]));
  qei_enc_model enc2 (.ref_clk(ref_clk), .a(enc_a[1]), .b(enc_b[1]));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    // Every request must have had its answer by the end of the run.
    check(32'(notes.size()), 32'h0);
    $display("Comparisons %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [31:0] e, input logic ee);
    notes.push_back('{e, ee});
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'h1;
    // No cycle count is assumed here; only the watchdog ends a wait with no answer.
    do begin
      @(posedge ref_clk);
    end while (pready_ff !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d, 4'hF, 32'h0, 1'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0, 4'hF, e, 1'h0);
  endtask

  task automatic ch_rd(input int ch, input int sub, input logic [31:0] e);
    rd(8'(16 * ch + 16 + 4 * sub), e);
  endtask

  task automatic setup(input logic [7:0] id, input logic m, input logic [15:0] l,
    input logic [15:0] t);
    wr(8'h00, {16'h0, l});
    wr(8'h04, {16'h0, t});
    wr(8'h08, {23'h0, m, id});
    rd(8'h0C, (id == 8'h1 || id == 8'h2) ? 32'h1 : 32'h2);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    check(32'(irq_ff), 32'(e));
  endtask

  // Answers are matched in order, so an extra ready shows up at once and a lost one when the watchdog ends the run.
  always @(posedge ref_clk) begin
    if (pready_ff === 1'h1) begin
      if (notes.size() == 0) check(32'h0, 32'h1);
      else begin
        nt = notes.pop_front();
        check(prdata_ff, nt.d);
        check(32'(pslverr_ff), 32'(nt.e));
      end
    end
  end

  initial begin
    #(40000 * 50);
    errors++;
    finish_test();
  end

  initial begin
    r = $urandom(72);
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h0);
    ch_rd(2, 3, 32'h0);
    r = $urandom_range(16'hFFFF);
    wr(8'h00, 32'(r[15:0]));
    xfer(1'h1, 8'h00, 32'h0, 4'h3, 32'h0, 1'h1);
    xfer(1'h0, 8'h18, 32'h0, 4'hF, 32'h0, 1'h1);
    rd(8'h00, 32'(r[15:0]));
    rd(8'h08, 32'h0);
    setup(bad[0], 1'h0, 16'h0, 16'h0);
    rd(8'h10, 32'h4);
    irq_is(1'h0);
    wr(8'h14, 32'h4);
    irq_is(1'h1);
    wr(8'h10, 32'h4);
    irq_is(1'h0);
    rd(8'h10, 32'h0);
    setup(8'h1, 1'h0, 16'h0, 16'h0);
    setup(8'h2, 1'h0, 16'h0, 16'h0);
    n1 = $urandom_range(40, 1);
    enc1.move(1'h1, n1, 4);
    enc2.move(1'h0, 3, 4);
    ch_rd(1, 0, 32'(n1));
    ch_rd(2, 0, 32'h7FFD);
    ch_rd(1, 1, 32'h0);
    enc1.slip(1'h1, 4, 1);
    enc1.slip(1'h1, 6, 4);
    ch_rd(1, 0, 32'(n1));
    ch_rd(1, 3, 32'h0);
    setup(8'h1, 1'h1, 16'h40, 16'h5);
    enc1.move(1'h1, 140, 5);
    ch_rd(1, 1, 32'(PPG * (qei_pkg::MS_PER_MIN / GATE) / 64));
    ch_rd(1, 2, 32'(qei_pkg::QEI_DIR_FWD));
    setup(8'h1, 1'h1, 16'h1, 16'h0);
    enc1.move(1'h0, 140, 5);
    ch_rd(1, 1, 32'(qei_pkg::VAL_MAX));
    ch_rd(1, 2, 32'(qei_pkg::QEI_DIR_REV));
    repeat (450) @(posedge ref_clk);
    ch_rd(1, 1, 32'h0);
    ch_rd(1, 2, 32'(qei_pkg::QEI_DIR_STOP));
    wr(8'h14, 32'h7);
    setup(8'h1, 1'h0, 16'h3, 16'h0);
    foreach (bad[i]) setup(bad[i], 1'h0, 16'h0, 16'h0);
    enc1.slip(1'h1, 3, 4);
    ch_rd(1, 3, 32'h0);
    enc1.slip(1'h1, 1, 4);
    ch_rd(1, 3, 32'(qei_pkg::ERR_A));
    rd(8'h10, 32'h5);
    setup(8'h1, 1'h0, 16'h2, 16'h1);
    enc1.slip(1'h1, 3, 90);
    ch_rd(1, 3, 32'h0);
    enc1.slip(1'h1, 6, 4);
    ch_rd(1, 3, 32'(qei_pkg::ERR_A));
    setup(8'h1, 1'h0, 16'h2, 16'h0);
    enc1.slip(1'h1, 3, 90);
    ch_rd(1, 3, 32'(qei_pkg::ERR_A));
    wr(8'h10, 32'h7);
    setup(8'h2, 1'h0, 16'h2, 16'h0);
    enc2.slip(1'h0, 3, 4);
    ch_rd(2, 3, 32'(qei_pkg::ERR_B));
    rd(8'h10, 32'h2);
    irq_is(1'h1);
    wr(8'h14, 32'h0);
    irq_is(1'h0);
    finish_test();
  end
endmodule
